// [cns_chan.sv]
// one canceller's suppressor gain tracker and comfort noise scaler
// assumes rates, scale and noise come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module cns_chan
  import cns_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic suppress,
  input wire logic [15:0] release_rate,
  input wire logic [15:0] engage_rate,
  input wire logic [15:0] scale,
  input wire logic [15:0] noise_in,
  output logic [15:0] gain,
  output logic [15:0] noise_out
);

  cns_chan_t st_ff;
  cns_chan_t nxt_st;
  logic [31:0] prod;
  logic [17:0] ramped;
  logic signed [32:0] nprod;
  logic signed [32:0] nshift;

  // gain ramps once per sample; clamp keeps it at or under unity
  always_comb begin
    nxt_st = st_ff;
    prod = 32'(st_ff.gain) *
      32'(suppress ? engage_rate : release_rate);
    ramped = prod[31:CNS_GAIN_FRAC];
    // both factors widened to the product first so no bit is lost
    nprod = 33'($signed(noise_in)) *
      33'($signed({1'b0, scale}));
    nshift = nprod >>> CNS_SCALE_FRAC;
    if (tick) begin
      if (ramped > 18'(CNS_GAIN_UNITY)) begin
        nxt_st.gain = CNS_GAIN_UNITY;
      end else begin
        nxt_st.gain = ramped[15:0];
      end
      // scale is read live, so a byte write counts from the next sample
      if (nshift > 33'sd32767) begin
        nxt_st.noise = 16'h7fff;
      end else if (nshift < -33'sd32768) begin
        nxt_st.noise = 16'h8000;
      end else begin
        nxt_st.noise = nshift[15:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff.gain <= CNS_GAIN_UNITY;
      st_ff.noise <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign gain = st_ff.gain;
  assign noise_out = st_ff.noise;

  a_gain_capped: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff.gain <= CNS_GAIN_UNITY)
    else $error("suppressor gain above unity");

  a_gain_engage: assert property (@(posedge clk) disable iff (!rst_n)
    tick && suppress && st_ff.gain != 16'h0 && engage_rate < CNS_GAIN_UNITY
    |=> st_ff.gain < $past(st_ff.gain))
    else $error("gain did not fall while engaging");

  a_gain_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !tick |=> $stable(st_ff.gain) && $stable(st_ff.noise))
    else $error("gain or noise moved between samples");

  a_noise_zero: assert property (@(posedge clk) disable iff (!rst_n)
    tick && (noise_in == 16'h0 || scale == 16'h0) |=> st_ff.noise == 16'h0)
    else $error("zero noise or zero scale gave nonzero output");

  c_engage: cover property (@(posedge clk) disable iff (!rst_n)
    tick && suppress ##1 st_ff.gain < CNS_GAIN_UNITY);

endmodule // cns_chan
`default_nettype wire

// [cns_pkg.sv]
// constants, register map and types for the comfort noise scale bank
// assumes a single 200 MHz clock and an 8-bit register port with page pins
package cns_pkg;

  // clock and sample timing
  localparam int CNS_CLK_PERIOD_PS = 5000;
  localparam int CNS_SAMPLE_PERIOD_NS = 125000;
  localparam int CNS_SAMPLE_CYCLES =
    (CNS_SAMPLE_PERIOD_NS * 1000) / CNS_CLK_PERIOD_PS;

  // page codes on {page_select_high, page_select_low}
  localparam logic [1:0] CNS_PAGE_CTRL = 2'h0;
  localparam logic [1:0] CNS_PAGE_SCALE = 2'h3;

  // byte offsets inside a page
  localparam logic [10:0] CNS_OFS_MAIN_CTRL = 11'h000;
  localparam logic [10:0] CNS_OFS_A_GAIN_LO = 11'h004;
  localparam logic [10:0] CNS_OFS_A_GAIN_HI = 11'h005;
  localparam logic [10:0] CNS_OFS_A_SCALE_LO = 11'h00c;
  localparam logic [10:0] CNS_OFS_A_SCALE_HI = 11'h00d;
  localparam logic [10:0] CNS_OFS_B_GAIN_LO = 11'h024;
  localparam logic [10:0] CNS_OFS_B_GAIN_HI = 11'h025;
  localparam logic [10:0] CNS_OFS_B_SCALE_LO = 11'h02c;
  localparam logic [10:0] CNS_OFS_B_SCALE_HI = 11'h02d;

  // reset values
  localparam logic [7:0] CNS_RST_SCALE_HI = 8'h01;
  localparam logic [7:0] CNS_RST_SCALE_LO = 8'haa;
  localparam logic [7:0] CNS_RST_MAIN_CTRL = 8'h00;
  localparam logic [7:0] CNS_RST_RDATA = 8'h00;

  // gain format: unity is 1.0, fraction in the low 14 bits
  localparam logic [15:0] CNS_GAIN_UNITY = 16'h4000;
  localparam int CNS_GAIN_FRAC = 14;
  // noise scale fraction bits: 16'h0100 passes noise unchanged
  localparam int CNS_SCALE_FRAC = 8;

  typedef struct packed {
    logic [7:0] main_ctrl;
    logic [7:0] a_scale_hi;
    logic [7:0] a_scale_lo;
    logic [7:0] b_scale_hi;
    logic [7:0] b_scale_lo;
    logic [7:0] a_gain_shadow;
    logic [7:0] b_gain_shadow;
    logic [7:0] rdata;
  } cns_regs_t;

  typedef struct packed {
    logic [15:0] gain;
    logic [15:0] noise;
  } cns_chan_t;

  typedef struct packed {
    logic [31:0] count;
    logic tick;
  } cns_tick_t;

endpackage

// [cns_regs.sv]
// register bank for the two cancellers' comfort noise scale and gain
// readback, plus main control register 0 of the group.
// assumes an 8-bit register port on the device clock: one-cycle write and
// read strobes, page pins beside the address, read data one cycle later.
`timescale 1ns/1ps
`default_nettype none

module cns_regs
  import cns_pkg::*;
#(
  parameter int SAMPLE_CYCLES = CNS_SAMPLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic page_select_high,
  input wire logic page_select_low,
  input wire logic [10:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  output logic [7:0] main_ctrl,
  input wire logic canceller_a_suppress,
  input wire logic [15:0] canceller_a_release_rate,
  input wire logic [15:0] canceller_a_engage_rate,
  input wire logic [15:0] canceller_a_noise_in,
  output logic [15:0] canceller_a_noise_out,
  input wire logic canceller_b_suppress,
  input wire logic [15:0] canceller_b_release_rate,
  input wire logic [15:0] canceller_b_engage_rate,
  input wire logic [15:0] canceller_b_noise_in,
  output logic [15:0] canceller_b_noise_out,
  output logic sample_tick
);

  cns_regs_t st_ff;
  cns_regs_t nxt_st;
  logic [1:0] page;
  logic on_scale_page;
  logic on_ctrl_page;
  logic tick;
  logic [15:0] a_scale;
  logic [15:0] b_scale;
  logic [15:0] a_gain;
  logic [15:0] b_gain;
  logic mapped;

  // page decode from the two page pins
  assign page = {page_select_high, page_select_low};
  assign on_scale_page = (page == CNS_PAGE_SCALE);
  assign on_ctrl_page = (page == CNS_PAGE_CTRL);

  // the full scale word is assembled from the two byte registers
  assign a_scale = {st_ff.a_scale_hi, st_ff.a_scale_lo};
  assign b_scale = {st_ff.b_scale_hi, st_ff.b_scale_lo};

  // one divider feeds both cancellers so their samples stay aligned
  cns_tick #(
    .PERIOD(SAMPLE_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  cns_chan u_chan_a (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .suppress(canceller_a_suppress),
    .release_rate(canceller_a_release_rate),
    .engage_rate(canceller_a_engage_rate),
    .scale(a_scale),
    .noise_in(canceller_a_noise_in),
    .gain(a_gain),
    .noise_out(canceller_a_noise_out)
  );

  cns_chan u_chan_b (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .suppress(canceller_b_suppress),
    .release_rate(canceller_b_release_rate),
    .engage_rate(canceller_b_engage_rate),
    .scale(b_scale),
    .noise_in(canceller_b_noise_in),
    .gain(b_gain),
    .noise_out(canceller_b_noise_out)
  );

  // address map check, used only by the unmapped-read check below; the read path decodes on its own
  always_comb begin
    mapped = 1'b0;
    if (on_ctrl_page) begin
      mapped = (bus_addr == CNS_OFS_MAIN_CTRL);
    end else if (on_scale_page) begin
      case (bus_addr)
        CNS_OFS_A_GAIN_LO, CNS_OFS_A_GAIN_HI,
        CNS_OFS_A_SCALE_LO, CNS_OFS_A_SCALE_HI,
        CNS_OFS_B_GAIN_LO, CNS_OFS_B_GAIN_HI,
        CNS_OFS_B_SCALE_LO, CNS_OFS_B_SCALE_HI: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // register writes and reads; read data is zero except the cycle after
  // a read strobe. writes to gain offsets or unmapped spots are dropped.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = CNS_RST_RDATA;
    if (bus_wr && on_ctrl_page && bus_addr == CNS_OFS_MAIN_CTRL) begin
      nxt_st.main_ctrl = bus_wdata;
    end
    if (bus_wr && on_scale_page) begin
      case (bus_addr)
        CNS_OFS_A_SCALE_HI: nxt_st.a_scale_hi = bus_wdata;
        CNS_OFS_A_SCALE_LO: nxt_st.a_scale_lo = bus_wdata;
        CNS_OFS_B_SCALE_HI: nxt_st.b_scale_hi = bus_wdata;
        CNS_OFS_B_SCALE_LO: nxt_st.b_scale_lo = bus_wdata;
        default: ;
      endcase
    end
    if (bus_rd && on_ctrl_page && bus_addr == CNS_OFS_MAIN_CTRL) begin
      nxt_st.rdata = st_ff.main_ctrl;
    end
    // the gain moves on every sample; reading the low byte freezes the
    // high byte in a shadow so a low-then-high pair never tears
    if (bus_rd && on_scale_page) begin
      case (bus_addr)
        CNS_OFS_A_GAIN_LO: begin
          nxt_st.rdata = a_gain[7:0];
          nxt_st.a_gain_shadow = a_gain[15:8];
        end
        CNS_OFS_A_GAIN_HI: nxt_st.rdata = st_ff.a_gain_shadow;
        CNS_OFS_B_GAIN_LO: begin
          nxt_st.rdata = b_gain[7:0];
          nxt_st.b_gain_shadow = b_gain[15:8];
        end
        CNS_OFS_B_GAIN_HI: nxt_st.rdata = st_ff.b_gain_shadow;
        CNS_OFS_A_SCALE_HI: nxt_st.rdata = st_ff.a_scale_hi;
        CNS_OFS_A_SCALE_LO: nxt_st.rdata = st_ff.a_scale_lo;
        CNS_OFS_B_SCALE_HI: nxt_st.rdata = st_ff.b_scale_hi;
        CNS_OFS_B_SCALE_LO: nxt_st.rdata = st_ff.b_scale_lo;
        default: nxt_st.rdata = CNS_RST_RDATA;
      endcase
    end
  end

  // power-up values; the scale defaults to the compliant noise level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff.main_ctrl <= CNS_RST_MAIN_CTRL;
      st_ff.a_scale_hi <= CNS_RST_SCALE_HI;
      st_ff.a_scale_lo <= CNS_RST_SCALE_LO;
      st_ff.b_scale_hi <= CNS_RST_SCALE_HI;
      st_ff.b_scale_lo <= CNS_RST_SCALE_LO;
      st_ff.a_gain_shadow <= CNS_GAIN_UNITY[15:8];
      st_ff.b_gain_shadow <= CNS_GAIN_UNITY[15:8];
      st_ff.rdata <= CNS_RST_RDATA;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // sample tick is echoed out so the surroundings can pace noise input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= tick;
    end
  end

  assign bus_rdata = st_ff.rdata;
  assign main_ctrl = st_ff.main_ctrl;

  // checks on the register port
  a_scale_reset: assert property (@(posedge clk)
    $rose(rst_n) |-> a_scale == 16'h01aa && b_scale == 16'h01aa)
    else $error("scale not at power-up default");

  a_write_a_hi: assert property (@(posedge clk) disable iff (!rst_n)
    bus_wr && on_scale_page && bus_addr == CNS_OFS_A_SCALE_HI
    |=> a_scale[15:8] == $past(bus_wdata) && $stable(a_scale[7:0]))
    else $error("high byte write did not land in upper scale bits");

  a_write_b_lo: assert property (@(posedge clk) disable iff (!rst_n)
    bus_wr && on_scale_page && bus_addr == CNS_OFS_B_SCALE_LO
    |=> b_scale[7:0] == $past(bus_wdata) && $stable(b_scale[15:8]))
    else $error("low byte write did not land in lower scale bits");

  a_page_gate: assert property (@(posedge clk) disable iff (!rst_n)
    bus_wr && !on_scale_page |=> $stable(a_scale) && $stable(b_scale))
    else $error("scale changed by a write off page 3");

  a_ctrl_write: assert property (@(posedge clk) disable iff (!rst_n)
    bus_wr && on_ctrl_page && bus_addr == CNS_OFS_MAIN_CTRL
    |=> main_ctrl == $past(bus_wdata))
    else $error("main control write lost");

  a_gain_read: assert property (@(posedge clk) disable iff (!rst_n)
    bus_rd && on_scale_page && bus_addr == CNS_OFS_A_GAIN_LO ##1
    bus_rd && on_scale_page && bus_addr == CNS_OFS_A_GAIN_HI
    |=> bus_rdata == $past(a_gain[15:8], 2))
    else $error("gain high byte not from the low-read snapshot");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
    bus_rd && !mapped |=> bus_rdata == 8'h00)
    else $error("unmapped read returned nonzero");

  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !bus_rd |=> bus_rdata == 8'h00)
    else $error("read data present without a read");

  a_scale_live: assert property (@(posedge clk) disable iff (!rst_n)
    bus_wr && on_scale_page && bus_addr == CNS_OFS_A_SCALE_LO
    |=> u_chan_a.scale[7:0] == $past(bus_wdata))
    else $error("scale write not visible to the noise path");

  // the other two byte lanes land where their partners above do
  a_write_a_lo: assert property (@(posedge clk) disable iff (!rst_n)
    bus_wr && on_scale_page && bus_addr == CNS_OFS_A_SCALE_LO
    |=> a_scale[7:0] == $past(bus_wdata) && $stable(a_scale[15:8]))
    else $error("low byte write did not land in lower scale bits");

  a_write_b_hi: assert property (@(posedge clk) disable iff (!rst_n)
    bus_wr && on_scale_page && bus_addr == CNS_OFS_B_SCALE_HI
    |=> b_scale[15:8] == $past(bus_wdata) && $stable(b_scale[7:0]))
    else $error("high byte write did not land in upper scale bits");

  // scale bytes read back what the noise path is using
  a_scale_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    bus_rd && on_scale_page && bus_addr == CNS_OFS_A_SCALE_HI
    |=> bus_rdata == $past(a_scale[15:8]))
    else $error("scale high byte read back wrong");

  a_scale_read_b: assert property (@(posedge clk) disable iff (!rst_n)
    bus_rd && on_scale_page && bus_addr == CNS_OFS_B_SCALE_LO
    |=> bus_rdata == $past(b_scale[7:0]))
    else $error("scale low byte read back wrong");

  // the control byte only moves on its own address
  a_ctrl_gated: assert property (@(posedge clk) disable iff (!rst_n)
    bus_wr && !(on_ctrl_page && bus_addr == CNS_OFS_MAIN_CTRL)
    |=> $stable(main_ctrl))
    else $error("main control changed by a write elsewhere");

  a_ctrl_read: assert property (@(posedge clk) disable iff (!rst_n)
    bus_rd && on_ctrl_page && bus_addr == CNS_OFS_MAIN_CTRL
    |=> bus_rdata == $past(main_ctrl))
    else $error("main control read back wrong");

  // gain readback: low byte live, high byte from the snapshot
  a_gain_lo_read: assert property (@(posedge clk) disable iff (!rst_n)
    bus_rd && on_scale_page && bus_addr == CNS_OFS_A_GAIN_LO
    |=> bus_rdata == $past(a_gain[7:0]))
    else $error("gain low byte not the live value");

  a_gain_hi_only: assert property (@(posedge clk) disable iff (!rst_n)
    bus_rd && on_scale_page && bus_addr == CNS_OFS_A_GAIN_HI
    |=> bus_rdata == $past(st_ff.a_gain_shadow))
    else $error("gain high byte not from the snapshot");

  a_gain_read_b: assert property (@(posedge clk) disable iff (!rst_n)
    bus_rd && on_scale_page && bus_addr == CNS_OFS_B_GAIN_LO ##1
    bus_rd && on_scale_page && bus_addr == CNS_OFS_B_GAIN_HI
    |=> bus_rdata == $past(b_gain[15:8], 2))
    else $error("second gain high byte not from the low-read snapshot");

  // only a read may refresh a snapshot, so writes to gain are dropped
  a_shadow_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !bus_rd |=> $stable(st_ff.a_gain_shadow) && $stable(st_ff.b_gain_shadow))
    else $error("gain snapshot moved without a read");

  // the echoed tick marks the cycle the new sample appears
  a_tick_echo: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> sample_tick)
    else $error("sample tick not echoed one cycle later");

  c_scale_write: cover property (@(posedge clk) disable iff (!rst_n)
    bus_wr && on_scale_page && bus_addr == CNS_OFS_B_SCALE_HI);

  c_gain_pair: cover property (@(posedge clk) disable iff (!rst_n)
    bus_rd && bus_addr == CNS_OFS_A_GAIN_LO ##1
    bus_rd && bus_addr == CNS_OFS_A_GAIN_HI);

  c_gain_pair_b: cover property (@(posedge clk) disable iff (!rst_n)
    bus_rd && bus_addr == CNS_OFS_B_GAIN_LO ##1
    bus_rd && bus_addr == CNS_OFS_B_GAIN_HI);

  c_ctrl_write: cover property (@(posedge clk) disable iff (!rst_n)
    bus_wr && on_ctrl_page && bus_addr == CNS_OFS_MAIN_CTRL);

endmodule // cns_regs
`default_nettype wire

// [cns_tick.sv]
// sample-rate divider: one-cycle enable per sample period
// assumes clk is the 200 MHz device clock
`timescale 1ns/1ps
`default_nettype none
module cns_tick
  import cns_pkg::*;
#(
  parameter int PERIOD = CNS_SAMPLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);

  cns_tick_t st_ff;
  cns_tick_t nxt_st;

  // count up; the tick is set in the cycle the count wraps to zero
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.count == 32'(PERIOD - 1)) begin
      nxt_st.count = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.count = st_ff.count + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

  a_tick_single: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff.tick |=> !st_ff.tick)
    else $error("sample tick lasted more than one cycle");

endmodule // cns_tick
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the comfort noise scale register bank
// assumes cns_pkg and cns_regs are compiled first; bench drives every port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cns_pkg::*;
  localparam int SC = 16; // short sample period keeps the run brief
  logic clk, rst_n, page_select_high, page_select_low, bus_wr, bus_rd;
  logic [10:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, main_ctrl;
  logic a_sup, b_sup, sample_tick;
  logic [15:0] a_rel, a_eng, a_nin, a_nout, b_rel, b_eng, b_nin, b_nout;
  logic [15:0] ga, gb, s, n;
  logic [15:0] rd_q[$];
  logic [15:0] na_q[$];
  logic [15:0] nb_q[$];
  logic rd_seen = 1'b0;
  int miscompares = 0;
  int n_compared = 0;

  cns_regs #(.SAMPLE_CYCLES(SC)) cns_regs_i (
    .clk, .rst_n, .page_select_high, .page_select_low, .bus_addr,
    .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .main_ctrl,
    .canceller_a_suppress(a_sup), .canceller_a_release_rate(a_rel),
    .canceller_a_engage_rate(a_eng), .canceller_a_noise_in(a_nin),
    .canceller_a_noise_out(a_nout),
    .canceller_b_suppress(b_sup), .canceller_b_release_rate(b_rel),
    .canceller_b_engage_rate(b_eng), .canceller_b_noise_in(b_nin),
    .canceller_b_noise_out(b_nout), .sample_tick);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one-cycle write strobe; a free edge follows so strobes never collide
  task automatic wr(input logic [1:0] pg, input logic [10:0] a,
                    input logic [7:0] d);
    @(posedge clk);
    {page_select_high, page_select_low} <= pg;
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  // the expected byte is queued before the strobe so the watcher finds it
  task automatic rd(input logic [1:0] pg, input logic [10:0] a,
                    input logic [7:0] e);
    rd_q.push_back({8'h00, e});
    @(posedge clk);
    {page_select_high, page_select_low} <= pg;
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
  endtask

  // low then high gain byte with no gap, so the snapshot path is used
  task automatic rd_pair(input logic [10:0] a, input logic [15:0] e);
    rd_q.push_back({8'h00, e[7:0]});
    rd_q.push_back({8'h00, e[15:8]});
    @(posedge clk);
    {page_select_high, page_select_low} <= 2'h3;
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_addr <= a + 11'h001;
    @(posedge clk);
    bus_rd <= 1'b0;
  endtask

  task automatic wait_tick();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (sample_tick !== 1'b1 && k < 4 * SC);
    if (sample_tick !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
  endtask

  // signed noise times unsigned scale with eight fraction bits, saturated
  function automatic logic [15:0] scaled(input logic [15:0] x,
                                         input logic [15:0] sc);
    logic signed [33:0] p;
    p = $signed(x) * $signed({1'b0, sc});
    p = p >>> 8;
    if (p > 34'sh7fff) return 16'h7fff;
    if (p < -34'sh8000) return 16'h8000;
    return p[15:0];
  endfunction

  function automatic logic [15:0] ramp(input logic [15:0] g,
                                       input logic [15:0] r);
    logic [31:0] p;
    p = ({16'h0000, g} * {16'h0000, r}) >> 14;
    return (p > 32'h4000) ? 16'h4000 : p[15:0];
  endfunction

  // new scales land between two samples and must shape the very next one
  task automatic noise_pair(input logic [15:0] sa, input logic [15:0] xa,
                            input logic [15:0] sb, input logic [15:0] xb);
    wait_tick();
    wr(2'h3, CNS_OFS_A_SCALE_HI, sa[15:8]);
    wr(2'h3, CNS_OFS_A_SCALE_LO, sa[7:0]);
    wr(2'h3, CNS_OFS_B_SCALE_HI, sb[15:8]);
    wr(2'h3, CNS_OFS_B_SCALE_LO, sb[7:0]);
    rd(2'h3, CNS_OFS_A_SCALE_HI, sa[15:8]);
    rd(2'h3, CNS_OFS_B_SCALE_LO, sb[7:0]);
    a_nin <= xa;
    b_nin <= xb;
    @(negedge clk);
    na_q.push_back(scaled(xa, sa));
    nb_q.push_back(scaled(xb, sb));
    wait_tick();
  endtask

  // gain model advances once per sample with the rate then in force
  task automatic gain_step();
    wait_tick();
    ga = ramp(ga, a_sup ? a_eng : a_rel);
    gb = ramp(gb, b_sup ? b_eng : b_rel);
    rd(2'h3, CNS_OFS_A_GAIN_LO, ga[7:0]);
    rd(2'h3, CNS_OFS_A_GAIN_HI, ga[15:8]);
    rd(2'h3, CNS_OFS_B_GAIN_LO, gb[7:0]);
    rd(2'h3, CNS_OFS_B_GAIN_HI, gb[15:8]);
    rd_pair(CNS_OFS_A_GAIN_LO, ga);
    rd_pair(CNS_OFS_B_GAIN_LO, gb);
  endtask

  // watcher: read data in the cycle after a read, noise at each sample
  always @(posedge clk) begin
    if (rd_seen) begin
      chk({8'h00, bus_rdata}, rd_q.pop_front());
    end
    if (sample_tick === 1'b1 && na_q.size() > 0) begin
      chk(a_nout, na_q.pop_front());
    end
    if (sample_tick === 1'b1 && nb_q.size() > 0) begin
      chk(b_nout, nb_q.pop_front());
    end
    rd_seen <= bus_rd;
  end

  initial begin
    rst_n = 1'b0;
    {page_select_high, page_select_low, bus_wr, bus_rd} = 4'h0;
    bus_addr = 11'h000;
    bus_wdata = 8'h00;
    {a_sup, b_sup} = 2'h0;
    {a_rel, a_eng, b_rel, b_eng} = {4{16'h4000}};
    {a_nin, b_nin} = 32'h0;
    ga = 16'h4000;
    gb = 16'h4000;
    void'($urandom(11035));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // power-up contents of every mapped byte
    rd(2'h3, CNS_OFS_A_SCALE_HI, 8'h01);
    rd(2'h3, CNS_OFS_A_SCALE_LO, 8'haa);
    rd(2'h3, CNS_OFS_B_SCALE_HI, 8'h01);
    rd(2'h3, CNS_OFS_B_SCALE_LO, 8'haa);
    rd(2'h0, CNS_OFS_MAIN_CTRL, 8'h00);
    rd(2'h3, CNS_OFS_A_GAIN_LO, 8'h00);
    rd(2'h3, CNS_OFS_A_GAIN_HI, 8'h40);
    rd(2'h3, CNS_OFS_B_GAIN_LO, 8'h00);
    rd(2'h3, CNS_OFS_B_GAIN_HI, 8'h40);
    // scale bytes ignore every page but 3; gain and unmapped stay put
    for (int p = 0; p < 3; p++) begin
      wr(p[1:0], CNS_OFS_A_SCALE_LO, 8'h55);
      wr(p[1:0], CNS_OFS_B_SCALE_HI, 8'h55);
    end
    wr(2'h3, CNS_OFS_A_GAIN_LO, 8'h12);
    rd(2'h3, CNS_OFS_A_SCALE_LO, 8'haa);
    rd(2'h3, CNS_OFS_B_SCALE_HI, 8'h01);
    rd(2'h0, CNS_OFS_A_SCALE_LO, 8'h00);
    rd(2'h3, CNS_OFS_A_GAIN_LO, 8'h00);
    rd(2'h3, 11'h7ff, 8'h00);
    // control byte lives on page 0 only
    s = 16'($urandom());
    wr(2'h0, CNS_OFS_MAIN_CTRL, s[7:0]);
    wr(2'h3, CNS_OFS_MAIN_CTRL, ~s[7:0]);
    @(negedge clk);
    chk({8'h00, main_ctrl}, {8'h00, s[7:0]});
    rd(2'h0, CNS_OFS_MAIN_CTRL, s[7:0]);
    rd(2'h3, CNS_OFS_MAIN_CTRL, 8'h00);
    // rising scales on fixed positive and negative noise, then random
    for (int i = 0; i < 7; i++) begin
      s = (i == 6) ? 16'hffff : (16'h0001 << (2 * i));
      noise_pair(s, 16'h1000, s, 16'hf000);
    end
    for (int i = 0; i < 8; i++) begin
      s = 16'($urandom());
      n = 16'($urandom());
      noise_pair(s, n, ~s, ~n);
    end
    // suppression pulls gain down, release brings it back to the clamp
    a_eng <= 16'h2000;
    b_eng <= 16'h3000;
    a_sup <= 1'b1;
    b_sup <= 1'b1;
    repeat (3) gain_step();
    a_rel <= 16'h8000;
    b_rel <= 16'h6000;
    a_sup <= 1'b0;
    b_sup <= 1'b0;
    repeat (4) gain_step();
    repeat (4) @(posedge clk);
    if (rd_q.size() + na_q.size() + nb_q.size() != 0) begin
      miscompares++;
    end
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
